/* dv/ccm_far_model.sv */
// Far-side model: trigger sources, comparator and fault levels, time base period
`timescale 1ns/100ps
module ccm_far_model
   import ccm_pkg::*;
(
   // Clock and reset
   input  wire logic       i_mclk,
   input  wire logic       i_rst,
   // Requested levels and rollover period, zero stops the time base
   input  wire ccm_ext_t   i_ext_req,
   input  wire logic [3:0] i_period,
   // Toward the block
   output ccm_ext_t        o_ext,
   output logic            o_tb_rollover,
   output logic            o_alt_sync
);
   logic [3:0] cnt_reg;  // Cycles since the last rollover
   // Levels move just after an edge; restarting the count keeps bench windows exact
   always_ff @(posedge i_mclk) begin
      o_ext <= i_ext_req;
      if (i_rst || i_period == 4'h0) begin
         cnt_reg       <= 4'h0;
         o_tb_rollover <= 1'b0;
         o_alt_sync    <= 1'b0;
      end else if (cnt_reg == i_period - 4'h1) begin
         cnt_reg       <= 4'h0;
         o_tb_rollover <= 1'b1;
         o_alt_sync    <= ~o_alt_sync;
      end else begin
         cnt_reg       <= cnt_reg + 4'h1;
         o_tb_rollover <= 1'b0;
      end
   end
endmodule : ccm_far_model

/* dv/tb_capture_compare_mode_trigger_shutdown.sv */
// Register-call testbench for the capture/compare control core
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin n_mismatch++; \
   $display("MISMATCH %s exp %0h got %0h", nm, ex, got); end end
module tb_capture_compare_mode_trigger_shutdown;
   import ccm_pkg::*;
   logic        i_mclk = 1'b0;
   logic        i_rst  = 1'b1;
   logic [7:0]  i_addr = 8'h00;
   logic [15:0] i_wdata = 16'h0000;
   logic        i_wr = 1'b0;
   logic        i_rd = 1'b0;
   logic [15:0] o_rdata;
   ccm_ext_t    ext_req = '0;
   ccm_ext_t    i_ext;
   logic [3:0]  period = 4'h0;
   logic        roll, alt, free_run, irq, sd, sync_out;
   ccm_mode_t   mode;
   int          n_mismatch = 0;
   int          checks_done = 0;
   int          n_irq, n_sync, n_rst, n_cap;
   logic        cnt_clr = 1'b1;
   logic        tb_run, restart, cap_ev, ext_in;
   // Clock at 10 MHz
   always #50 i_mclk = ~i_mclk;
   ccm_far_model i_ccm_far_model (.i_mclk(i_mclk), .i_rst(i_rst), .i_ext_req(ext_req),
      .i_period(period), .o_ext(i_ext), .o_tb_rollover(roll), .o_alt_sync(alt));
   ccm_core i_ccm_core (.i_mclk(i_mclk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_ext(i_ext), .i_tb_rollover(roll),
      .i_alt_sync(alt), .o_mode(mode), .o_tb_run(tb_run), .o_tb_restart(restart),
      .o_sync_out(sync_out), .o_free_run(free_run), .o_irq(irq), .o_shutdown(sd),
      .o_cap_event(cap_ev), .o_ext_input(ext_in));
   // Pulse counters; only this process writes them, tests steer them through cnt_clr
   always @(posedge i_mclk) begin
      n_irq  <= cnt_clr ? 0 : n_irq + int'(irq);
      n_sync <= cnt_clr ? 0 : n_sync + int'(sync_out);
      n_rst  <= cnt_clr ? 0 : n_rst + int'(restart);
      n_cap  <= cnt_clr ? 0 : n_cap + int'(cap_ev);
   end
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge i_mclk);
      i_wr    <= 1'b1;
      i_addr  <= a;
      i_wdata <= d;
      @(posedge i_mclk);
      i_wr <= 1'b0;
   endtask : wr
   // Read data stand only in the cycle after the strobe edge
   task automatic rd(input logic [7:0] a, input logic [15:0] ex);
      @(posedge i_mclk);
      i_rd   <= 1'b1;
      i_addr <= a;
      @(posedge i_mclk);
      i_rd <= 1'b0;
      #1 `CHK("rdata", ex, o_rdata)
   endtask : rd
   task automatic summarize;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : summarize
   // Watchdog, far beyond the expected run length
   initial begin
      #3ms;
      n_mismatch++;
      summarize();
   end
   initial begin
      automatic logic [15:0] ofs [5] = '{16'h00, 16'h04, 16'h08, 16'h0C, 16'h14};
      automatic logic [15:0] msk [5] = '{16'h803F, 16'hCFFF, 16'hD0FF, 16'h7007, 16'h0000};
      automatic int          ps [4] = '{0, 2, 3, 2};
      ccm_ext_t    e;
      repeat (5) @(posedge i_mclk);
      i_rst <= 1'b0;
      // Reset values, writable masks, unmapped address
      foreach (ofs[k]) rd(ofs[k][7:0], 16'h0000);
      foreach (ofs[k]) begin
         wr(ofs[k][7:0], 16'hFFFF);
         rd(ofs[k][7:0], msk[k]);
         wr(ofs[k][7:0], 16'h0000);
      end
      // Every compare and capture code
      for (int m = 0; m < 16; m++) begin
         wr(CCM_OFS_CON1L, 16'h8000 | 16'(m));
         repeat (2) @(posedge i_mclk);
         `CHK("cmp_rsv", logic'(m > 7 && m < 15), mode.reserved)
         `CHK("timer", logic'(m == 0), mode.timer_only)
         if (m > 0 && m < 4) `CHK("edge", 2'(m), mode.edge_act)
         if (m == 4 || m == 5) `CHK("dual", 1'b1, mode.dual_edge)
         if (m == 6) `CHK("center", 1'b1, mode.center)
         if (m == 7) `CHK("vfp", 1'b1, mode.var_freq)
         `CHK("ext", logic'(m == 15), mode.ext_input)
         `CHK("out_en", logic'(m > 0 && m < 8), mode.out_enable)
         `CHK("buf", logic'(m == 5 || m == 6), mode.buffered)
         wr(CCM_OFS_CON1L, 16'h8010 | 16'(m));
         repeat (2) @(posedge i_mclk);
         `CHK("cap_rsv", logic'(m > 5), mode.reserved)
         `CHK("cap", 1'b1, mode.capture)
      end
      // No external sync only while the module is on
      wr(CCM_OFS_CON1H, 16'h001F);
      wr(CCM_OFS_CON1L, 16'h0000);
      repeat (2) @(posedge i_mclk);
      `CHK("free_off", 1'b0, free_run)
      wr(CCM_OFS_CON1L, 16'h8000);
      repeat (2) @(posedge i_mclk);
      `CHK("free_on", 1'b1, free_run)
      // Postscaler over twelve rollovers; last entry counts absent trigger outputs
      foreach (ps[k]) begin
         wr(CCM_OFS_CON1L, 16'h0000);
         wr(CCM_OFS_CON1H, (k == 3 ? 16'h801F : 16'h001F) | 16'(ps[k] << 8));
         wr(CCM_OFS_CON1L, 16'h8000);
         @(posedge i_mclk);
         period  <= 4'h4;
         cnt_clr <= 1'b0;
         repeat (51) @(posedge i_mclk);
         period  <= 4'h0;
         cnt_clr <= 1'b1;
         `CHK("irq", (k == 3) ? 0 : 12 / (ps[k] + 1), n_irq)
         `CHK("sync", 12, n_sync)
      end
      // Each source enable against its own wired source; enables three and four have none and must stay low
      for (int b = 0; b < 8; b++) begin
         e = '0;
         if (b < 3) e.cmp[b] = 1'b1;
         e.sd_cell       = (b == 5);
         e.fault_input_a = (b == 6);
         e.fault_input_b = (b == 7);
         ext_req <= e;
         repeat (6) @(posedge i_mclk);
         `CHK("sd_dis", 1'b0, sd)
         wr(CCM_OFS_CON2L, 16'(1 << b));
         repeat (6) @(posedge i_mclk);
         `CHK("sd_en", logic'(b != 3 && b != 4), sd)
         ext_req <= '0;
         wr(CCM_OFS_CON2L, 16'h0000);
         repeat (4) @(posedge i_mclk);
         wr(CCM_OFS_STAT, 16'h0000);
         repeat (2) @(posedge i_mclk);
         `CHK("sd_clr", 1'b0, sd)
      end
      // Deferred software shutdown, then automatic restart at a rollover
      wr(CCM_OFS_CON2L, 16'h5000);
      repeat (6) @(posedge i_mclk);
      `CHK("defer", 1'b0, sd)
      period <= 4'h4;
      repeat (8) @(posedge i_mclk);
      `CHK("soft", 1'b1, sd)
      wr(CCM_OFS_CON2L, 16'h8000);
      repeat (8) @(posedge i_mclk);
      `CHK("restart", 1'b0, sd)
      // Eight-period one-shot from comparator one; retrigger blocked, then allowed
      wr(CCM_OFS_CON1L, 16'h0000);
      wr(CCM_OFS_CON3H, 16'h7000);
      wr(CCM_OFS_CON1H, 16'h80D8);
      wr(CCM_OFS_CON1L, 16'h8000);
      cnt_clr <= 1'b0;
      repeat (2) @(posedge i_mclk);
      `CHK("armed", 1'b0, tb_run)
      e = '0;
      e.cmp[0] = 1'b1;
      for (int t = 0; t < 3; t++) begin
         ext_req <= e;
         repeat (8) @(posedge i_mclk);
         ext_req <= '0;
         `CHK("trig_run", 1'b1, tb_run)
         `CHK("restarts", (t == 2) ? 2 : 1, n_rst)
         if (t == 1) wr(CCM_OFS_CON1H, 16'hC0D8);
         repeat (4) @(posedge i_mclk);
      end
      // Rollover phase is free, so the end lands 29 to 32 cycles after the last start
      repeat (20) @(posedge i_mclk);
      `CHK("shot_long", 1'b1, tb_run)
      repeat (5) @(posedge i_mclk);
      `CHK("shot_end", 1'b0, tb_run)
      `CHK("trig_irq", 2, n_irq)
      cnt_clr <= 1'b1;
      // Every fourth rising edge of logic cell one; postscale two gives one interrupt per two captures
      wr(CCM_OFS_CON1L, 16'h0000);
      wr(CCM_OFS_CON3H, 16'h0004);
      wr(CCM_OFS_CON1H, 16'h011F);
      wr(CCM_OFS_CON1L, 16'h8014);
      cnt_clr <= 1'b0;
      for (int t = 0; t < 16; t++) begin
         e = '0;
         e.cell_out[0] = t[0];
         ext_req <= e;
         repeat (3) @(posedge i_mclk);
      end
      repeat (4) @(posedge i_mclk);
      `CHK("cap4", 2, n_cap)
      `CHK("cap_irq", 1, n_irq)
      // External input mode follows the selected source level
      wr(CCM_OFS_CON1L, 16'h800F);
      repeat (2) @(posedge i_mclk);
      `CHK("ext_hi", 1'b1, ext_in)
      ext_req <= '0;
      repeat (5) @(posedge i_mclk);
      `CHK("ext_lo", 1'b0, ext_in)
      summarize();
   end
endmodule : tb_capture_compare_mode_trigger_shutdown

/* rtl/ccm_core.sv */
// Capture/compare mode decode, triggering, sync select, postscaler and auto-shutdown
//
// The placing of the registers and the address-and-strobe port were decided locally.
`timescale 1ns/100ps
module ccm_core
   import ccm_pkg::*;
#(
   parameter bit MULTI_OUTPUT = 1'b1, // Centre-aligned mode present
   parameter bit SD_CELL_EN   = 1'b1  // Logic cell shutdown source wired
) (
   // Clock and reset
   input  wire logic        i_mclk,
   input  wire logic        i_rst,
   // Register port
   input  wire logic [7:0]  i_addr,
   input  wire logic [15:0] i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic      [15:0] o_rdata,
   // Asynchronous trigger, shutdown and capture sources
   input  wire ccm_ext_t    i_ext,
   // Same-clock time base and alternate sync signals
   input  wire logic        i_tb_rollover,
   input  wire logic        i_alt_sync,
   // Mode and control outputs
   output ccm_mode_t        o_mode,
   output logic             o_tb_run,
   output logic             o_tb_restart,
   output logic             o_sync_out,
   output logic             o_free_run,
   output logic             o_irq,
   output logic             o_shutdown,
   output logic             o_cap_event,
   output logic             o_ext_input
);
   // Register storage
   logic [15:0] con1l_reg;    // Enable, width, capture select, mode
   logic [15:0] con1h_reg;    // Postscaler, trigger, sync select
   logic [15:0] con2l_reg;    // Shutdown control
   logic [15:0] con3h_reg;    // One-shot extend count, capture source
   logic        flag_reg;     // Shutdown event flag
   ccm_ext_t    ext_s;        // Synchronised external inputs

   // Field views
   wire         f_on    = con1l_reg[CCM_B_ON];
   wire         f_capt  = con1l_reg[CCM_B_CAPT];
   wire [3:0]   f_mode  = con1l_reg[CCM_B_MODE +: 4];
   wire         f_pssrc = con1h_reg[CCM_B_PSSRC];
   wire         f_rtrg  = con1h_reg[CCM_B_RTRG];
   wire [3:0]   f_ops   = con1h_reg[CCM_B_OPS +: 4];
   wire         f_trig  = con1h_reg[CCM_B_TRIG];
   wire         f_shot  = con1h_reg[CCM_B_SHOT];
   wire         f_alt   = con1h_reg[CCM_B_ALT];
   wire [4:0]   f_sync  = con1h_reg[CCM_B_SYNC +: 5];
   wire         f_rsen  = con2l_reg[CCM_B_RSEN];
   wire         f_defer = con2l_reg[CCM_B_DEFER];
   wire         f_soft  = con2l_reg[CCM_B_SOFT];
   wire [7:0]   f_sden  = con2l_reg[CCM_B_SDEN +: 8];
   wire [2:0]   f_osc   = con3h_reg[CCM_B_OSC +: 3];
   wire [2:0]   f_csrc  = con3h_reg[CCM_B_CSRC +: 3];

   // Every pin-side source passes two flops before use
   ccm_sync2 #(.WIDTH($bits(ccm_ext_t))) u_sync (
      .i_mclk  (i_mclk),
      .i_rst   (i_rst),
      .i_async (i_ext),
      .o_sync  (ext_s)
   );

   // Register decode
   wire sel_1l = (i_addr == CCM_OFS_CON1L);
   wire sel_1h = (i_addr == CCM_OFS_CON1H);
   wire sel_2l = (i_addr == CCM_OFS_CON2L);
   wire sel_3h = (i_addr == CCM_OFS_CON3H);
   wire sel_st = (i_addr == CCM_OFS_STAT);
   // Writable masks keep unimplemented bits at zero
   wire [15:0] wm_1l = 16'h803F;
   wire [15:0] wm_1h = 16'hCFFF;
   wire [15:0] wm_2l = 16'hD0FF;
   wire [15:0] wm_3h = 16'h7007;

   // Control register writes
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         con1l_reg <= CCM_RST_REG;
         con1h_reg <= CCM_RST_REG;
         con2l_reg <= CCM_RST_REG;
         con3h_reg <= CCM_RST_REG;
      end else if (i_wr) begin
         if (sel_1l) con1l_reg <= i_wdata & wm_1l;
         if (sel_1h) con1h_reg <= i_wdata & wm_1h;
         if (sel_2l) con2l_reg <= i_wdata & wm_2l;
         if (sel_3h) con3h_reg <= i_wdata & wm_3h;
      end
   end

   // Mode decode, compare side
   wire cmp_on   = f_on & ~f_capt;
   wire m_timer  = cmp_on & (f_mode == CCM_M_0000);
   wire m_single = cmp_on & (f_mode inside {CCM_M_HIGH, CCM_M_LOW, CCM_M_TGL});
   wire m_dual   = cmp_on & (f_mode inside {CCM_M_DUAL, CCM_M_DBUF});
   wire m_ctr    = cmp_on & (f_mode == CCM_M_CTR) & MULTI_OUTPUT;
   wire m_vfp    = cmp_on & (f_mode == CCM_M_VFP);
   wire m_ext    = cmp_on & (f_mode == CCM_M_EXT);
   // Mode decode, capture side
   wire cap_on   = f_on & f_capt;
   wire c_both   = cap_on & (f_mode inside {CCM_M_0000, CCM_M_TGL});
   wire c_rise   = cap_on & (f_mode == CCM_M_HIGH);
   wire c_fall   = cap_on & (f_mode == CCM_M_LOW);
   wire c_r4     = cap_on & (f_mode == CCM_M_DUAL);
   wire c_r16    = cap_on & (f_mode == CCM_M_DBUF);
   // Anything left over while enabled is reserved, centre mode included when absent
   wire m_resv   = f_on & ~(m_timer | m_single | m_dual | m_ctr | m_vfp | m_ext
                            | c_both | c_rise | c_fall | c_r4 | c_r16);
   ccm_mode_t mode_next;
   always_comb begin
      mode_next            = '0;
      mode_next.capture    = cap_on;
      mode_next.wide       = con1l_reg[CCM_B_WIDE];
      mode_next.timer_only = m_timer;
      mode_next.out_enable = m_single | m_dual | m_ctr | m_vfp;
      mode_next.edge_act   = m_single ? f_mode[1:0] : 2'h0;
      mode_next.dual_edge  = m_dual;
      mode_next.buffered   = m_dual & f_mode[0] | m_ctr;
      mode_next.center     = m_ctr;
      mode_next.var_freq   = m_vfp;
      mode_next.ext_input  = m_ext;
      mode_next.reserved   = m_resv;
   end

   // Capture and external source select; codes six and seven read low
   wire [7:0] csrc_vec = {2'h0, ext_s.cell_out, ext_s.cmp, ext_s.cap_pin};
   wire       csrc_lvl = csrc_vec[f_csrc];
   logic      csrc_d_reg;                                        // Previous level, edge detect

   // Sync source vector; reserved codes stay low
   logic      sync_out_reg;
   logic [31:0] sync_vec;
   always_comb begin
      sync_vec                   = '0;
      sync_vec[CCM_S_CHG]        = ext_s.charge_time_trigger;
      sync_vec[CCM_S_ADC]        = ext_s.adc_start;
      sync_vec[CCM_S_CMP1 +: 3]  = ext_s.cmp;
      sync_vec[CCM_S_CELL1 +: 2] = ext_s.cell_out;
      sync_vec[CCM_S_INT0 +: 3]  = ext_s.int_pad;
      sync_vec[CCM_S_MOD1 +: 4]  = ext_s.mod_sync;
      sync_vec[CCM_S_OWN]        = sync_out_reg;
      sync_vec[CCM_S_TMR]        = i_tb_rollover;
   end
   wire  no_sync  = (f_sync == CCM_S_NONE);
   wire  sync_lvl = ~no_sync & sync_vec[f_sync];
   logic sync_d_reg;
   wire  trig_evt = f_on & sync_lvl & ~sync_d_reg;              // Rising edge of chosen source

   // Time base control
   ccm_tb_t tb_reg;
   ccm_tb_t tb_next;
   logic [2:0] shot_reg;                                        // Periods done in one-shot
   logic [2:0] shot_next;
   logic       restart_next;
   wire        shot_end = f_shot & i_tb_rollover & (shot_reg == f_osc);
   always_comb begin
      tb_next      = tb_reg;
      shot_next    = shot_reg;
      restart_next = 1'b0;
      unique case (tb_reg)
         TB_OFF: begin
            if (f_on) tb_next = f_trig ? TB_ARMED : TB_RUN;
         end
         TB_ARMED: begin
            if (trig_evt) begin
               tb_next      = TB_RUN;
               restart_next = 1'b1;
               shot_next    = 3'h0;
            end
         end
         TB_RUN: begin
            if (f_trig && f_rtrg && trig_evt) begin
               restart_next = 1'b1;
               shot_next    = 3'h0;
            end else if (!f_trig && trig_evt) begin
               restart_next = 1'b1;                             // Plain sync reset
            end else if (f_trig && shot_end) begin
               tb_next      = TB_ARMED;
            end else if (i_tb_rollover && shot_reg != f_osc) begin
               shot_next    = shot_reg + 3'h1;
            end
            if (!f_trig && tb_next == TB_RUN && f_on) tb_next = TB_RUN;
         end
      endcase
      if (!f_on) tb_next = TB_OFF;
      else if (!f_trig && tb_reg == TB_ARMED) tb_next = TB_RUN;
      else if (f_trig && tb_reg == TB_RUN && !f_shot && !restart_next) tb_next = TB_RUN;
   end
   wire trig_accept = restart_next & f_trig;                    // Module trigger output event

   // Shutdown condition and flag
   wire [7:0] sd_src = {ext_s.fault_input_b, ext_s.fault_input_a,
                        ext_s.sd_cell & SD_CELL_EN, 2'h0, ext_s.cmp};
   wire sd_cond  = |(sd_src & f_sden) | f_soft;
   wire sd_set   = f_on & sd_cond & (~f_defer | i_tb_rollover);
   wire sd_auto  = f_rsen & ~sd_cond & i_tb_rollover;
   wire sd_swclr = i_wr & sel_st & ~i_wdata[CCM_B_FLAG];
   wire flag_next = sd_set | (flag_reg & ~sd_auto & ~sd_swclr); // Set wins over clear

   // Capture edge and prescale
   logic [3:0] cap_cnt_reg;
   wire rise = csrc_lvl & ~csrc_d_reg;
   wire fall = ~csrc_lvl & csrc_d_reg;
   wire cap_gate = ~flag_reg;                                   // Shutdown gates capture
   wire [3:0] cap_top = c_r16 ? CCM_CAP_N16 : CCM_CAP_N4;
   wire cap_pre  = (c_r4 | c_r16) & rise;
   wire cap_hit  = cap_pre & (cap_cnt_reg == cap_top);
   wire cap_next = cap_gate & (c_both & (rise | fall) | c_rise & rise
                                | c_fall & fall | cap_hit);

   // Postscaler
   logic [3:0] ps_reg;
   wire ps_evt = cap_on ? cap_next
               : (f_pssrc ? trig_accept : i_tb_rollover);
   wire ps_hit = f_on & ps_evt & (ps_reg == f_ops);

   // Sync output source
   wire sync_next = f_alt ? i_alt_sync : i_tb_rollover;

   // Event and state flops
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         tb_reg       <= TB_OFF;
         shot_reg     <= 3'h0;
         flag_reg     <= 1'b0;
         sync_d_reg   <= 1'b0;
         csrc_d_reg   <= 1'b0;
         cap_cnt_reg  <= 4'h0;
         ps_reg       <= 4'h0;
         sync_out_reg <= 1'b0;
      end else begin
         tb_reg       <= tb_next;
         shot_reg     <= shot_next;
         flag_reg     <= flag_next;
         sync_d_reg   <= sync_lvl;
         csrc_d_reg   <= csrc_lvl;
         sync_out_reg <= f_on & sync_next;
         // Capture prescale restarts when off or at its count
         if (!(c_r4 | c_r16) || cap_hit) cap_cnt_reg <= 4'h0;
         else if (cap_pre) cap_cnt_reg <= cap_cnt_reg + 4'h1;
         // Postscaler wraps at its match
         if (!f_on || ps_hit) ps_reg <= 4'h0;
         else if (ps_evt) ps_reg <= ps_reg + 4'h1;
      end
   end

   // Registered outputs
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         o_mode       <= '0;
         o_tb_run     <= 1'b0;
         o_tb_restart <= 1'b0;
         o_free_run   <= 1'b0;
         o_irq        <= 1'b0;
         o_shutdown   <= 1'b0;
         o_cap_event  <= 1'b0;
         o_ext_input  <= 1'b0;
      end else begin
         o_mode       <= mode_next;
         o_tb_run     <= (tb_next == TB_RUN);
         o_tb_restart <= restart_next;
         o_free_run   <= f_on & no_sync;
         o_irq        <= ps_hit;
         o_shutdown   <= flag_next;
         o_cap_event  <= cap_next;
         o_ext_input  <= m_ext & csrc_lvl;
      end
   end
   assign o_sync_out = sync_out_reg;

   // Read data, one cycle after the strobe; unmapped reads return zero
   wire [15:0] stat_w = {13'h0, sd_cond, (tb_reg == TB_RUN), flag_reg};
   wire [15:0] rd_mux = sel_1l ? con1l_reg : sel_1h ? con1h_reg : sel_2l ? con2l_reg
                      : sel_3h ? con3h_reg : sel_st ? stat_w : 16'h0000;
   always_ff @(posedge i_mclk) begin
      if (i_rst) o_rdata <= 16'h0000;
      else o_rdata <= i_rd ? rd_mux : 16'h0000;
   end

   // Checks
   sequence s_armed_trig;
      tb_reg == TB_ARMED && f_on && f_trig && trig_evt;
   endsequence
   sequence s_run_out;
      o_tb_run && o_tb_restart;
   endsequence
   property p_trig_start;
      @(posedge i_mclk) disable iff (i_rst) s_armed_trig |=> s_run_out;
   endproperty
   a_trig_start: assert property (p_trig_start) else $error("trigger did not start");
   property p_no_retrig;
      @(posedge i_mclk) disable iff (i_rst)
         tb_reg == TB_RUN && f_on && f_trig && !f_rtrg && trig_evt |=> !o_tb_restart;
   endproperty
   a_no_retrig: assert property (p_no_retrig) else $error("blocked retrigger fired");
   property p_irq_cause;
      @(posedge i_mclk) disable iff (i_rst)
         o_irq |-> $past(ps_evt) && $past(ps_reg) == $past(f_ops);
   endproperty
   a_irq_cause: assert property (p_irq_cause) else $error("irq without postscale match");
   property p_sd_now;
      @(posedge i_mclk) disable iff (i_rst) f_on && sd_cond && !f_defer |=> o_shutdown;
   endproperty
   a_sd_now: assert property (p_sd_now) else $error("immediate shutdown missed");
   property p_sd_wait;
      @(posedge i_mclk) disable iff (i_rst)
         !flag_reg && f_defer && !i_tb_rollover |=> !flag_reg;
   endproperty
   a_sd_wait: assert property (p_sd_wait) else $error("deferred shutdown too early");
   property p_restart;
      @(posedge i_mclk) disable iff (i_rst)
         flag_reg && f_rsen && !sd_cond && i_tb_rollover |=> !o_shutdown;
   endproperty
   a_restart: assert property (p_restart) else $error("auto restart missed");
   property p_sync_src;
      @(posedge i_mclk) disable iff (i_rst) f_on && !f_alt && i_tb_rollover |=> o_sync_out;
   endproperty
   a_sync_src: assert property (p_sync_src) else $error("sync output missing");
   property p_timer_only;
      @(posedge i_mclk) disable iff (i_rst) o_mode.timer_only |-> !o_mode.out_enable;
   endproperty
   a_timer_only: assert property (p_timer_only) else $error("timer mode drives output");
   property p_shot_end;
      @(posedge i_mclk) disable iff (i_rst)
         tb_reg == TB_RUN && f_on && f_trig && !trig_evt && shot_end |=> !o_tb_run;
   endproperty
   a_shot_end: assert property (p_shot_end) else $error("one-shot did not stop");
endmodule : ccm_core

/* rtl/ccm_pkg.sv */
// Package of register map, field layout, codes and carrier types for the capture/compare control
package ccm_pkg;
   // Register byte offsets
   localparam logic [7:0] CCM_OFS_CON1L = 8'h00;
   localparam logic [7:0] CCM_OFS_CON1H = 8'h04;
   localparam logic [7:0] CCM_OFS_CON2L = 8'h08;
   localparam logic [7:0] CCM_OFS_CON3H = 8'h0C;
   localparam logic [7:0] CCM_OFS_STAT  = 8'h10;
   // Reset values
   localparam logic [15:0] CCM_RST_REG  = 16'h0000;
   // Control one low fields
   localparam int CCM_B_ON    = 15;
   localparam int CCM_B_WIDE  = 5;
   localparam int CCM_B_CAPT  = 4;
   localparam int CCM_B_MODE  = 0;
   // Control one high fields
   localparam int CCM_B_PSSRC = 15;
   localparam int CCM_B_RTRG  = 14;
   localparam int CCM_B_OPS   = 8;
   localparam int CCM_B_TRIG  = 7;
   localparam int CCM_B_SHOT  = 6;
   localparam int CCM_B_ALT   = 5;
   localparam int CCM_B_SYNC  = 0;
   // Control two low fields
   localparam int CCM_B_RSEN  = 15;
   localparam int CCM_B_DEFER = 14;
   localparam int CCM_B_SOFT  = 12;
   localparam int CCM_B_SDEN  = 0;
   // Control three high and status fields
   localparam int CCM_B_OSC   = 12;
   localparam int CCM_B_CSRC  = 0;
   localparam int CCM_B_FLAG  = 0;
   localparam int CCM_B_RUN   = 1;
   localparam int CCM_B_COND  = 2;
   // Mode codes
   localparam logic [3:0] CCM_M_0000 = 4'h0;
   localparam logic [3:0] CCM_M_HIGH = 4'h1;
   localparam logic [3:0] CCM_M_LOW  = 4'h2;
   localparam logic [3:0] CCM_M_TGL  = 4'h3;
   localparam logic [3:0] CCM_M_DUAL = 4'h4;
   localparam logic [3:0] CCM_M_DBUF = 4'h5;
   localparam logic [3:0] CCM_M_CTR  = 4'h6;
   localparam logic [3:0] CCM_M_VFP  = 4'h7;
   localparam logic [3:0] CCM_M_EXT  = 4'hF;
   // Capture prescale counts
   localparam logic [3:0] CCM_CAP_N4  = 4'h3;
   localparam logic [3:0] CCM_CAP_N16 = 4'hF;
   // Sync source select codes
   localparam logic [4:0] CCM_S_NONE  = 5'h1F;
   localparam logic [4:0] CCM_S_CHG   = 5'h1C;
   localparam logic [4:0] CCM_S_ADC   = 5'h1B;
   localparam logic [4:0] CCM_S_CMP1  = 5'h18;
   localparam logic [4:0] CCM_S_CELL1 = 5'h10;
   localparam logic [4:0] CCM_S_INT0  = 5'h09;
   localparam logic [4:0] CCM_S_MOD1  = 5'h02;
   localparam logic [4:0] CCM_S_OWN   = 5'h01;
   localparam logic [4:0] CCM_S_TMR   = 5'h00;
   // External inputs, all asynchronous to the module clock
   typedef struct packed {
      logic       fault_input_b;
      logic       fault_input_a;
      logic       sd_cell;
      logic [2:0] cmp;
      logic [1:0] cell_out;
      logic [2:0] int_pad;
      logic [3:0] mod_sync;
      logic       charge_time_trigger;
      logic       adc_start;
      logic       cap_pin;
   } ccm_ext_t;
   // Decoded operating mode
   typedef struct packed {
      logic       capture;
      logic       wide;
      logic       timer_only;
      logic       out_enable;
      logic [1:0] edge_act;
      logic       dual_edge;
      logic       buffered;
      logic       center;
      logic       var_freq;
      logic       ext_input;
      logic       reserved;
   } ccm_mode_t;
   // Time base run states
   typedef enum logic [1:0] {TB_OFF, TB_ARMED, TB_RUN} ccm_tb_t;
endpackage : ccm_pkg

/* rtl/ccm_sync2.sv */
// Two-stage synchroniser for a vector of asynchronous levels
`timescale 1ns/100ps
module ccm_sync2 #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input  wire logic             i_mclk,
   input  wire logic             i_rst,
   // Asynchronous levels in, synchronised levels out
   input  wire logic [WIDTH-1:0] i_async,
   output logic      [WIDTH-1:0] o_sync
);
   logic [WIDTH-1:0] meta_reg; // First stage, read only by second stage

   // One pair of flops per bit
   genvar g;
   generate
      for (g = 0; g < WIDTH; g++) begin : g_bit
         always_ff @(posedge i_mclk) begin
            if (i_rst) begin
               meta_reg[g] <= 1'b0;
               o_sync[g]   <= 1'b0;
            end else begin
               meta_reg[g] <= i_async[g];
               o_sync[g]   <= meta_reg[g];
            end
         end
      end
   endgenerate
endmodule : ccm_sync2
